// ### reload_timer_defines.vh
// constants for the dual reload down timer
//
// How it works
// R01: channel 1 count decrementing to zero sets the channel 1 zero flag, bit 7.
// R02: channel 0 count decrementing to zero sets the channel 0 zero flag, bit 6.
// R03: a channel requests an interrupt one cycle after its flag and enable are both set, and drops one cycle after either clears.
// R04: a flag clears only after a control read followed by that channel's count read.
// R05: reset clears flags, interrupt enables, output-control bits and count enables.
// R06: at channel 1 zero the output field leaves, toggles, lowers or raises the pin.
// R07: the timer drives the shared pin only while dma1 address high byte bit 3 is set.
// R08: each count enable gates its channel's counting; zero after reset, so no decrement.
// R09: software may freely read and write count bytes while counting is stopped.
// R10: channel 0 count low, high, reload low, high sit at 0x0c through 0x0f.
// R11: channel 1 count low, high, reload low, high sit at 0x14 through 0x17.
// R12: a read-only free-running counter sits at 0x18; writes to it do nothing.
// R13: reaching zero while enabled reloads the count and counting carries on.
// R14: a write to one byte of a count or reload register leaves the other byte.
`ifndef RELOAD_TIMER_DEFINES_VH
`define RELOAD_TIMER_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_T0_CNT_LO 6'h0c
`define IDX_T0_CNT_HI 6'h0d
`define IDX_T0_RLD_LO 6'h0e
`define IDX_T0_RLD_HI 6'h0f
`define IDX_CTRL      6'h10
`define IDX_T1_CNT_LO 6'h14
`define IDX_T1_CNT_HI 6'h15
`define IDX_T1_RLD_LO 6'h16
`define IDX_T1_RLD_HI 6'h17
`define IDX_FREE      6'h18
`define IDX_DMA1_HIGH 6'h2d

// control register fields
`define CTL_FLAG1  7
`define CTL_FLAG0  6
`define CTL_IE1    5
`define CTL_IE0    4
`define CTL_OC_HI  3
`define CTL_OC_LO  2
`define CTL_EN1    1
`define CTL_EN0    0
`define DMA1_ROUTE 3

// output-control codes
`define OC_NONE   2'b00
`define OC_TOGGLE 2'b01
`define OC_LOW    2'b10
`define OC_HIGH   2'b11

// reset values
`define RST_CTRL  6'h00
`define RST_DMA1  8'h00
`define RST_FRC   8'hff
`define RST_COUNT 16'hffff

// axi responses
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

// timer tick: counts of aclk per count step
`define TICK_DIV 16'h0014

`endif

// ### tick_divider.v
// one-cycle enable pulse every div cycles of aclk
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter [15:0] DIV = 16'd20
) (
  input  wire       aclk,
  input  wire       aresetn,
  output reg        tick
);
  reg [15:0] cnt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == DIV - 16'd1) begin
      cnt  <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 16'd1;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider
`default_nettype wire

// ### timer_channel.v
// one 16-bit down counter with reload register
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_defines.vh"
module timer_channel (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        tick,
  input  wire        count_enable,
  input  wire        wr_cnt_lo,
  input  wire        wr_cnt_hi,
  input  wire        wr_rld_lo,
  input  wire        wr_rld_hi,
  input  wire [7:0]  wdata,
  output reg  [15:0] count,
  output reg  [15:0] reload,
  output reg         zero
);
  wire step;

  assign step = tick & count_enable; // see R08

  always @(posedge aclk) begin
    if (!aresetn) begin
      count  <= `RST_COUNT;
      reload <= `RST_COUNT;
      zero   <= 1'b0;
    end else begin
      zero <= 1'b0;
      // software write wins over a count step in the same cycle
      if (wr_cnt_lo) begin
        count[7:0] <= wdata; // see R09 see R14
      end else if (wr_cnt_hi) begin
        count[15:8] <= wdata; // see R09 see R14
      end else if (step) begin
        if (count <= 16'h0001) begin
          count <= reload; // see R13
          zero  <= 1'b1;
        end else begin
          count <= count - 16'h0001;
        end
      end
      if (wr_rld_lo) begin
        reload[7:0] <= wdata; // see R14
      end
      if (wr_rld_hi) begin
        reload[15:8] <= wdata; // see R14
      end
    end
  end
endmodule // timer_channel
`default_nettype wire

// ### dual_reload_down_timer.v
// two reload down timers and free-running counter behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_defines.vh"
module dual_reload_down_timer #(
  parameter [15:0] TICK_DIV = `TICK_DIV
) (
  input  wire        aclk,
  input  wire        aresetn,
  // write address
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  // write data
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // read address
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  // read data
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // shared output / dma request pin
  input  wire        dma_request_pin,
  output reg         timer_out_pin,
  output reg         timer_out_oe_n,
  output reg         dma_request_sync,
  // interrupt requests toward the processor
  output reg         chan0_irq,
  output reg         chan1_irq
);
  // control register fields, dma routing byte and free counter
  reg        chan1_zero_flag;
  reg        chan0_zero_flag;
  reg        chan1_irq_enable;
  reg        chan0_irq_enable;
  reg        out_ctl_hi;
  reg        out_ctl_lo;
  reg        chan1_count_enable;
  reg        chan0_count_enable;
  reg [7:0]  dma1_io_addr_high_byte;
  reg [7:0]  free_counter;

  // control-read arming for the flag clear sequence
  reg        chan0_armed;
  reg        chan1_armed;

  // held write address and data
  reg [5:0]  aw_idx;
  reg [7:0]  w_byte;
  reg        w_lane;

  reg        dma_meta;

  wire        tick;
  wire [15:0] chan0_count_reg;
  wire [15:0] chan1_count_reg;
  wire [15:0] chan0_reload_reg;
  wire [15:0] chan1_reload_reg;
  wire        chan0_zero;
  wire        chan1_zero;

  wire [7:0]  timer_control_reg;
  wire [5:0]  ar_idx;
  wire        do_write;
  wire        do_read;
  wire        wr_en;
  reg  [7:0]  read_byte;
  reg         read_hit;
  reg         write_hit;

  // clear pulses from the flag clear sequence
  wire        chan0_clear;
  wire        chan1_clear;
  wire        ctl_read;

  assign timer_control_reg = {chan1_zero_flag, chan0_zero_flag,
                              chan1_irq_enable, chan0_irq_enable,
                              out_ctl_hi, out_ctl_lo,
                              chan1_count_enable, chan0_count_enable};

  assign ar_idx   = araddr[7:2];
  assign do_write = !awready && !wready && !bvalid;
  assign do_read  = arvalid && arready;
  // only the low byte lane carries register data
  assign wr_en    = do_write && w_lane;

  assign ctl_read    = do_read && (ar_idx == `IDX_CTRL);
  assign chan0_clear = do_read && chan0_armed &&
                       (ar_idx == `IDX_T0_CNT_LO || ar_idx == `IDX_T0_CNT_HI); // see R04
  assign chan1_clear = do_read && chan1_armed &&
                       (ar_idx == `IDX_T1_CNT_LO || ar_idx == `IDX_T1_CNT_HI); // see R04

  tick_divider #(
    .DIV (TICK_DIV)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  timer_channel u_chan0 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .tick         (tick),
    .count_enable (chan0_count_enable),
    .wr_cnt_lo    (wr_en && aw_idx == `IDX_T0_CNT_LO), // see R10
    .wr_cnt_hi    (wr_en && aw_idx == `IDX_T0_CNT_HI), // see R10
    .wr_rld_lo    (wr_en && aw_idx == `IDX_T0_RLD_LO), // see R10
    .wr_rld_hi    (wr_en && aw_idx == `IDX_T0_RLD_HI), // see R10
    .wdata        (w_byte),
    .count        (chan0_count_reg),
    .reload       (chan0_reload_reg),
    .zero         (chan0_zero)
  );

  timer_channel u_chan1 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .tick         (tick),
    .count_enable (chan1_count_enable),
    .wr_cnt_lo    (wr_en && aw_idx == `IDX_T1_CNT_LO), // see R11
    .wr_cnt_hi    (wr_en && aw_idx == `IDX_T1_CNT_HI), // see R11
    .wr_rld_lo    (wr_en && aw_idx == `IDX_T1_RLD_LO), // see R11
    .wr_rld_hi    (wr_en && aw_idx == `IDX_T1_RLD_HI), // see R11
    .wdata        (w_byte),
    .count        (chan1_count_reg),
    .reload       (chan1_reload_reg),
    .zero         (chan1_zero)
  );

  // read decode
  always @* begin
    read_byte = 8'h00;
    read_hit  = 1'b1;
    case (ar_idx)
      `IDX_T0_CNT_LO: read_byte = chan0_count_reg[7:0];
      `IDX_T0_CNT_HI: read_byte = chan0_count_reg[15:8];
      `IDX_T0_RLD_LO: read_byte = chan0_reload_reg[7:0];
      `IDX_T0_RLD_HI: read_byte = chan0_reload_reg[15:8];
      `IDX_CTRL:      read_byte = timer_control_reg;
      `IDX_T1_CNT_LO: read_byte = chan1_count_reg[7:0];
      `IDX_T1_CNT_HI: read_byte = chan1_count_reg[15:8];
      `IDX_T1_RLD_LO: read_byte = chan1_reload_reg[7:0];
      `IDX_T1_RLD_HI: read_byte = chan1_reload_reg[15:8];
      `IDX_FREE:      read_byte = free_counter; // see R12
      `IDX_DMA1_HIGH: read_byte = dma1_io_addr_high_byte;
      default:        read_hit  = 1'b0;
    endcase
  end

  // write decode, only for the answer code; the stores act below
  always @* begin
    case (aw_idx)
      `IDX_T0_CNT_LO, `IDX_T0_CNT_HI,
      `IDX_T0_RLD_LO, `IDX_T0_RLD_HI,
      `IDX_T1_CNT_LO, `IDX_T1_CNT_HI,
      `IDX_T1_RLD_LO, `IDX_T1_RLD_HI,
      `IDX_CTRL, `IDX_DMA1_HIGH:
        write_hit = 1'b1;
      // free counter accepts the write and ignores it
      `IDX_FREE:
        write_hit = 1'b1; // see R12
      default:
        write_hit = 1'b0;
    endcase
  end

  // write channels: address and data are taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      aw_idx  <= 6'h00;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_idx  <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (do_read) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h00_0000, read_byte};
        rresp   <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // control register and dma routing byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      {chan1_irq_enable, chan0_irq_enable,
       out_ctl_hi, out_ctl_lo,
       chan1_count_enable, chan0_count_enable} <= `RST_CTRL; // see R05 see R08
      dma1_io_addr_high_byte <= `RST_DMA1;
    end else if (wr_en) begin
      if (aw_idx == `IDX_CTRL) begin
        chan1_irq_enable   <= w_byte[`CTL_IE1];
        chan0_irq_enable   <= w_byte[`CTL_IE0];
        out_ctl_hi         <= w_byte[`CTL_OC_HI];
        out_ctl_lo         <= w_byte[`CTL_OC_LO];
        chan1_count_enable <= w_byte[`CTL_EN1]; // see R08
        chan0_count_enable <= w_byte[`CTL_EN0]; // see R08
      end
      if (aw_idx == `IDX_DMA1_HIGH) begin
        dma1_io_addr_high_byte <= w_byte;
      end
    end
  end

  // zero flags: a count reaching zero beats a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan0_zero_flag <= 1'b0; // see R05
      chan1_zero_flag <= 1'b0; // see R05
    end else begin
      if (chan0_zero) begin
        chan0_zero_flag <= 1'b1; // see R02
      end else if (chan0_clear) begin
        chan0_zero_flag <= 1'b0; // see R04
      end
      if (chan1_zero) begin
        chan1_zero_flag <= 1'b1; // see R01
      end else if (chan1_clear) begin
        chan1_zero_flag <= 1'b0; // see R04
      end
    end
  end

  // a control read arms both channels; the next count read of a
  // channel consumes its arming
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan0_armed <= 1'b0;
      chan1_armed <= 1'b0;
    end else if (ctl_read) begin
      chan0_armed <= 1'b1; // see R04
      chan1_armed <= 1'b1; // see R04
    end else begin
      if (chan0_clear) begin
        chan0_armed <= 1'b0;
      end
      if (chan1_clear) begin
        chan1_armed <= 1'b0;
      end
    end
  end

  // interrupt requests follow flag and enable one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan0_irq <= 1'b0;
      chan1_irq <= 1'b0;
    end else begin
      chan0_irq <= chan0_zero_flag && chan0_irq_enable; // see R03
      chan1_irq <= chan1_zero_flag && chan1_irq_enable; // see R03
    end
  end

  // free-running counter steps on the timer tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      free_counter <= `RST_FRC;
    end else if (tick) begin
      free_counter <= free_counter - 8'h01; // see R12
    end
  end

  // shared pin: level keeps following channel 1 zero events even while routed away, so it
  // reappears with its current value when routing returns
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_out_pin  <= 1'b0;
      timer_out_oe_n <= 1'b1;
    end else begin
      timer_out_oe_n <= !dma1_io_addr_high_byte[`DMA1_ROUTE]; // see R07
      if (chan1_zero) begin
        case ({out_ctl_hi, out_ctl_lo}) // see R06
          `OC_TOGGLE: timer_out_pin <= !timer_out_pin;
          `OC_LOW:    timer_out_pin <= 1'b0;
          `OC_HIGH:   timer_out_pin <= 1'b1;
          default:    timer_out_pin <= timer_out_pin;
        endcase
      end
    end
  end

  // dma request pin arrives from outside the clock domain
  always @(posedge aclk) begin
    if (!aresetn) begin
      dma_meta         <= 1'b0;
      dma_request_sync <= 1'b0;
    end else begin
      dma_meta         <= dma_request_pin;
      dma_request_sync <= dma_meta;
    end
  end
endmodule // dual_reload_down_timer
`default_nettype wire

// ### timer_props.sv
// port assertions for the dual reload down timer
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_defines.vh"
module timer_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        timer_out_pin,
  input wire logic        timer_out_oe_n,
  input wire logic        chan0_irq,
  input wire logic        chan1_irq
);
  logic [7:0] ctl_s;
  logic       route_s;
  wire        wr_take = awvalid && awready && wvalid && wready;
  // shadow of what software stored, taken at the handshake edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl_s   <= 8'h00;
      route_s <= 1'b0;
    end else if (wr_take && wstrb[0]) begin
      if (awaddr[7:2] == `IDX_CTRL) ctl_s <= wdata[7:0];
      if (awaddr[7:2] == `IDX_DMA1_HIGH) route_s <= wdata[`DMA1_ROUTE];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // store and response come two edges after both handshakes
  property p_wr_resp;
    wr_take |=> !awready && !wready && !bvalid ##1 bvalid && !awready && !wready;
  endproperty
  property p_b_hold; bvalid |-> !awready && !wready; endproperty
  property p_rd_resp; arvalid && arready |=> rvalid && !arready; endproperty
  property p_unmapped;
    arvalid && arready && araddr[7:2] == 6'h3f |=> rresp == `RESP_SLVERR && rdata == 0;
  endproperty
  property p_free_wr;
    wr_take && awaddr[7:2] == `IDX_FREE |=> ##1 bvalid && bresp == `RESP_OKAY;
  endproperty
  property p_route;
    route_s == $past(route_s) && route_s == $past(route_s, 2) && route_s == $past(route_s, 3)
      |-> timer_out_oe_n == !route_s;
  endproperty
  property p_irq0_mask;
    !ctl_s[4] && !$past(ctl_s[4]) && !$past(ctl_s[4], 2) && !$past(ctl_s[4], 3) |-> !chan0_irq;
  endproperty
  property p_irq1_mask;
    !ctl_s[5] && !$past(ctl_s[5]) && !$past(ctl_s[5], 2) && !$past(ctl_s[5], 3) |-> !chan1_irq;
  endproperty
  property p_pin_ctl;
    timer_out_pin != $past(timer_out_pin)
      |-> ctl_s[3:2] != 0 || $past(ctl_s[3:2]) != 0 || $past(ctl_s[3:2], 2) != 0;
  endproperty
  property p_reset;
    $rose(aresetn) |-> !chan0_irq && !chan1_irq && timer_out_oe_n && !timer_out_pin && !bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_free_wr: assert property (p_free_wr) else $error("free counter write refused");
  a_route: assert property (p_route) else $error("pin routing wrong");
  a_irq0_mask: assert property (p_irq0_mask) else $error("irq0 unmasked");
  a_irq1_mask: assert property (p_irq1_mask) else $error("irq1 unmasked");
  a_pin_ctl: assert property (p_pin_ctl) else $error("pin moved with no control");
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  c_irq0: cover property (chan0_irq);
  c_irq1: cover property (chan1_irq);
  c_route: cover property (!timer_out_oe_n);
  c_pin: cover property ($changed(timer_out_pin));
endmodule // timer_props
bind dual_reload_down_timer timer_props chk (
  .aclk           (aclk),
  .aresetn        (aresetn),
  .awaddr         (awaddr),
  .awvalid        (awvalid),
  .awready        (awready),
  .wdata          (wdata),
  .wstrb          (wstrb),
  .wvalid         (wvalid),
  .wready         (wready),
  .bresp          (bresp),
  .bvalid         (bvalid),
  .bready         (bready),
  .araddr         (araddr),
  .arvalid        (arvalid),
  .arready        (arready),
  .rdata          (rdata),
  .rresp          (rresp),
  .rvalid         (rvalid),
  .rready         (rready),
  .timer_out_pin  (timer_out_pin),
  .timer_out_oe_n (timer_out_oe_n),
  .chan0_irq      (chan0_irq),
  .chan1_irq      (chan1_irq)
);
`default_nettype wire

// ### tb_dual_reload_down_timer.sv
// self-checking bench for the dual reload down timer
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_defines.vh"
module tb_dual_reload_down_timer;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 0;
  logic        awvalid = 0;
  logic        wvalid = 0;
  logic        bready = 0;
  logic        arvalid = 0;
  logic        rready = 0;
  logic        dma_request_pin = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        timer_out_pin, timer_out_oe_n, dma_request_sync, chan0_irq, chan1_irq;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rv;
  logic [7:0]  v, d8;
  int          err_total = 0;
  int          total_checks = 0;
  int          n;
  logic [5:0]  map [8] = '{`IDX_T0_CNT_LO, `IDX_T0_CNT_HI, `IDX_T0_RLD_LO, `IDX_T0_RLD_HI,
                           `IDX_T1_CNT_LO, `IDX_T1_CNT_HI, `IDX_T1_RLD_LO, `IDX_T1_RLD_HI};
  logic [1:0]  oc_tab [4] = '{`OC_HIGH, `OC_LOW, `OC_TOGGLE, `OC_NONE};
  logic        pin_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  // short tick so reload periods stay a few dozen cycles
  dual_reload_down_timer #(.TICK_DIV(16'd2)) uut (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .awaddr           (awaddr),
    .awvalid          (awvalid),
    .awready          (awready),
    .wdata            (wdata),
    .wstrb            (wstrb),
    .wvalid           (wvalid),
    .wready           (wready),
    .bresp            (bresp),
    .bvalid           (bvalid),
    .bready           (bready),
    .araddr           (araddr),
    .arvalid          (arvalid),
    .arready          (arready),
    .rdata            (rdata),
    .rresp            (rresp),
    .rvalid           (rvalid),
    .rready           (rready),
    .dma_request_pin  (dma_request_pin),
    .timer_out_pin    (timer_out_pin),
    .timer_out_oe_n   (timer_out_oe_n),
    .dma_request_sync (dma_request_sync),
    .chan0_irq        (chan0_irq),
    .chan1_irq        (chan1_irq)
  );

  always #5 aclk = ~aclk;

  task automatic note(input string nm, input logic bad, input logic [31:0] e, g);
    total_checks++;
    if (bad) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic chk_data(input string nm, input logic [31:0] e, g);
    note(nm, g !== e, e, g);
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, g);
    note(nm, g !== e, {30'h0, e}, {30'h0, g});
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    note(nm, g !== e, {31'h0, e}, {31'h0, g});
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic bus_rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(`IDX_CTRL, rv, rs);
    chk_data("control", 32'h0000_0000, rv);
    dma_request_pin <= 1'b1;
    repeat (20) @(posedge aclk);
    chk_bit("dma_sync", 1'b1, dma_request_sync);
    chk_bit("oe_n", 1'b1, timer_out_oe_n);
    bus_rd(`IDX_T0_CNT_LO, rv, rs);
    chk_data("count0_lo", 32'h0000_00ff, rv);
    bus_rd(`IDX_T1_CNT_HI, rv, rs);
    chk_data("count1_hi", 32'h0000_00ff, rv);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      bus_wr(map[i], 8'h31 + 8'(i * 17), rs);
      chk_resp("map_wr", `RESP_OKAY, rs);
    end
    for (int i = 0; i < 8; i++) begin
      bus_rd(map[i], rv, rs);
      chk_data("map_rd", {24'h00_0000, 8'h31 + 8'(i * 17)}, rv);
    end
    bus_rd(6'h3f, rv, rs);
    chk_resp("unmapped_rd", `RESP_SLVERR, rs);
    bus_wr(6'h3f, 8'h55, rs);
    chk_resp("unmapped_wr", `RESP_SLVERR, rs);
    bus_rd(`IDX_FREE, rv, rs);
    v = rv[7:0];
    bus_wr(`IDX_FREE, v + 8'h80, rs);
    chk_resp("free_wr", `RESP_OKAY, rs);
    repeat (40) @(posedge aclk);
    bus_rd(`IDX_FREE, rv, rs);
    d8 = v - rv[7:0];
    chk_bit("free_step", 1'b1, d8 >= 8'd10 && d8 <= 8'd60);
    $display("test map done");
    bus_wr(`IDX_T0_RLD_LO, 8'h05, rs);
    bus_wr(`IDX_T0_RLD_HI, 8'h00, rs);
    bus_wr(`IDX_T0_CNT_LO, 8'h03, rs);
    bus_wr(`IDX_T0_CNT_HI, 8'h00, rs);
    bus_wr(`IDX_CTRL, 8'h11, rs);
    for (n = 0; n < 200 && chan0_irq !== 1'b1; n++) @(posedge aclk);
    chk_bit("chan0_irq", 1'b1, chan0_irq);
    bus_wr(`IDX_CTRL, 8'h10, rs);
    bus_rd(`IDX_T0_CNT_LO, rv, rs);
    chk_bit("count0_reloaded", 1'b1, rv >= 1 && rv <= 5);
    bus_rd(`IDX_CTRL, rv, rs);
    chk_data("control_flag0", 32'h0000_0050, rv);
    bus_rd(`IDX_T0_CNT_HI, rv, rs);
    chk_data("count0_hi", 32'h0000_0000, rv);
    bus_rd(`IDX_CTRL, rv, rs);
    chk_data("control_clear", 32'h0000_0010, rv);
    chk_bit("chan0_irq", 1'b0, chan0_irq);
    $display("test channel0 done");
    bus_wr(`IDX_DMA1_HIGH, 8'h08, rs);
    repeat (3) @(posedge aclk);
    chk_bit("oe_n", 1'b0, timer_out_oe_n);
    bus_wr(`IDX_T1_RLD_LO, 8'h40, rs);
    bus_wr(`IDX_T1_RLD_HI, 8'h00, rs);
    for (int i = 0; i < 4; i++) begin
      bus_wr(`IDX_T1_CNT_LO, 8'h02, rs);
      bus_wr(`IDX_T1_CNT_HI, 8'h00, rs);
      // last pass enables the channel 1 request as well
      v = {2'b00, i == 3, 1'b0, oc_tab[i], 2'b10};
      bus_wr(`IDX_CTRL, v, rs);
      n = 0;
      do begin
        bus_rd(`IDX_CTRL, rv, rs);
        n++;
      end while (rv[7] !== 1'b1 && n < 20);
      bus_wr(`IDX_CTRL, v & 8'hfc, rs);
      chk_bit("flag1", 1'b1, rv[7]);
      chk_bit("pin", pin_tab[i], timer_out_pin);
      chk_bit("chan1_irq", i == 3, chan1_irq);
      // poll armed the clear, this read takes the flag down
      bus_rd(`IDX_T1_CNT_LO, rv, rs);
    end
    bus_wr(`IDX_DMA1_HIGH, 8'h00, rs);
    repeat (3) @(posedge aclk);
    chk_bit("oe_n", 1'b1, timer_out_oe_n);
    $display("test channel1 done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    $display("unexpected run_time: expected done, seen hang");
    print_verdict();
  end
endmodule // tb_dual_reload_down_timer
`default_nettype wire
